/* src/sync_serial_pkg.sv */
// register map, field positions, reset values and states of the synchronous serial channel
// assumes a 32-bit classic wishbone slave addressed in bytes, one register per aligned word
package sync_serial_pkg;
	localparam int ADR_W    = 8;
	localparam int DAT_W    = 32;
	localparam int DATA_MAX = 8;
	localparam int BAUD_W   = 16;

	localparam logic [ADR_W-1:0] OFF_CTRL  = 8'h00;
	localparam logic [ADR_W-1:0] OFF_STAT  = 8'h04;
	localparam logic [ADR_W-1:0] OFF_TXB   = 8'h08;
	localparam logic [ADR_W-1:0] OFF_RXB   = 8'h0C;
	localparam logic [ADR_W-1:0] OFF_BAUD  = 8'h10;
	localparam logic [ADR_W-1:0] OFF_INSEL = 8'h14;

	// control register fields
	localparam int CTL_BM     = 0;
	localparam int CTL_HB     = 4;
	localparam int CTL_PH     = 5;
	localparam int CTL_PO     = 6;
	localparam int CTL_LB     = 7;
	localparam int CTL_ERR_EN = 8;
	localparam int CTL_AREN   = 12;
	localparam int CTL_MS     = 14;
	localparam int CTL_EN     = 15;

	// status register fields; error flags share their order with the enables
	localparam int ERR_TE    = 0;
	localparam int ERR_RE    = 1;
	localparam int ERR_PE    = 2;
	localparam int ERR_BE    = 3;
	localparam int ST_BSY    = 4;
	localparam int ST_TXREQ  = 5;
	localparam int ST_RXFULL = 6;
	localparam int ST_BC     = 8;

	// input select fields
	localparam int SEL_MIS = 0;
	localparam int SEL_SIS = 2;
	localparam int SEL_CIS = 4;

	localparam logic [15:0] CTRL_RST      = 16'h0000;
	localparam logic [15:0] CTRL_WMASK    = 16'hDFF7;
	localparam logic [15:0] CTRL_WMASK_EN = 16'hC000;
	localparam logic [7:0]  INSEL_RST     = 8'h00;
	localparam logic [7:0]  INSEL_WMASK   = 8'h3F;
	localparam logic [15:0] BAUD_RST      = 16'h0000;
	localparam logic [1:0]  PH_WIN_AFTER  = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_TAIL  = 3'b100
	} shift_state_t;
endpackage

/* src/input_select3.sv */
// three-way input picker for receive data and slave clock lines
// assumes the inputs are already synchronous to the module clock
module input_select3 (
	input  wire logic [2:0] pins,
	input  wire logic [1:0] sel,
	output logic            y
);
	always_comb
	begin
		case (sel)
			2'h0: y = pins[0];
			2'h1: y = pins[1];
			2'h2: y = pins[2];
			// reserved code: a quiet zero rather than a guess
			default: y = 1'b0;
		endcase
	end
endmodule

/* src/baud_timer.sv */
// down-counting baud timer with reload; ticks once every reload+1 clocks while running
// assumes the reload value is left alone while the timer runs
module baud_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] reload,
	output logic                  tick,
	output logic [WIDTH-1:0]      count
);
	logic [WIDTH-1:0] cnt_q;

	if (WIDTH < 2)
	begin
		$error("baud_timer: WIDTH must be at least 2");
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (!run || cnt_q == '0)
			cnt_q <= reload;
		else
			cnt_q <= cnt_q - 1'b1;
	end

	assign tick  = run & (cnt_q == '0);
	assign count = cnt_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	reload_after_tick_a: assert property (tick ##1 run |-> count == $past(reload))
		else $error("timer did not reload after its tick");
	tick_at_one_a: assert property (run && count == 1 ##1 run |-> tick)
		else $error("timer skipped the tick after count one");
endmodule

/* src/sync_serial_channel.sv */
// synchronous serial channel: master or slave role, wishbone register access,
// half-duplex self check, back-to-back frames, baud timer and four error detectors
// assumes pins and bus are synchronous to ref_clk; pad direction comes from the enables
//
// Notes on behaviour
// - transmitter reads its own bits on receive input
// - transmit request shows transmit buffer empty
// - reloaded buffer starts next frame without gap
// - role picks clock and data lines automatically
// - bits 1:0 pick master receive input
// - bits 3:2 pick slave receive input
// - bits 5:4 pick slave clock; 7:6 zero
// - own 16-bit down-counting baud timer with reload
// - baud read: live count enabled, reload disabled
// - shift rate is clock over 2(reload+1)
// - reload zero master only; slave needs one
// - receive, phase always; transmit, baud slave only
// - sticky error flags, enabled ones raise interrupt
// - unread receive word overwritten, receive error set
// - data change near latch edge: phase error
// - half-clock rate full exchange gives phase error
// - slave clock off by factor two: baud error
// - baud error with auto reset resets channel
// - checker expects next edge right after transfer
// - slave clocked without new data: transmit error
//
// Added by the designer: the address map and register access over Wishbone.
module sync_serial_channel #(
	parameter int FRAME_MAX = sync_serial_pkg::DATA_MAX
) (
	input  wire logic                              ref_clk,
	input  wire logic                              rst_n,
	input  wire logic                              cyc,
	input  wire logic                              stb,
	input  wire logic                              we,
	input  wire logic [sync_serial_pkg::ADR_W-1:0] adr,
	input  wire logic [3:0]                        sel,
	input  wire logic [sync_serial_pkg::DAT_W-1:0] dat_w,
	output logic [sync_serial_pkg::DAT_W-1:0]      dat_r,
	output logic                                   ack,
	output logic                                   generated_shift_clock,
	output logic                                   generated_shift_clock_oe,
	input  wire logic [2:0]                        slave_clock_in,
	output logic                                   master_out_slave_in_pin,
	output logic                                   master_out_slave_in_pin_oe,
	input  wire logic [2:0]                        slave_rx_in,
	output logic                                   slave_out_master_in_pin,
	output logic                                   slave_out_master_in_pin_oe,
	input  wire logic [2:0]                        master_rx_in,
	output logic                                   tx_req,
	output logic                                   error_irq_line
);
	import sync_serial_pkg::*;

	if (FRAME_MAX != 8)
	begin
		$error("sync_serial_channel: frame width field only serves 8 bits");
	end

	logic             ack_q, bus_req, wr_go, rd_go, txb_wr, rxb_rd;
	logic [DAT_W-1:0] dat_r_q, rd_d;
	logic [15:0]      ctrl_q, ctrl_m, lane16;
	logic [7:0]       insel_q;
	logic [15:0]      baud_q, baud_cnt;
	logic [3:0]       err_q, err_hit, err_clr;
	logic [FRAME_MAX-1:0] tx_buf_q, tx_sr_q, tx_sr_d, rx_sr_q, rx_buf_q, rx_new;
	logic             tx_full_q, tx_loaded_q, rx_full_q, fresh_q, fresh_eff, out_q;
	logic             sclk_q, sck_prev_q, rxs1_q, armed_q;
	logic [1:0]       win_q;
	logic [2:0]       cnt_q, w_last;
	logic [17:0]      gap_q;
	logic [16:0]      exp_half;
	logic [18:0]      gap_x2;
	shift_state_t     st_q;
	logic en, ms, hb, ph, po, lb, aren, tick;
	logic mrx, srx, sck, rx_pin, rx_bit;
	logic m_edge, s_edge, edge_go, new_lvl, act, latch_go, shift_go, sh_go;
	logic fin, mst_start, slv_start, slv_load, end_load, load;
	logic te_hit, re_hit, pe_hit, be_hit, arst;

	assign en   = ctrl_q[CTL_EN];
	assign ms   = ctrl_q[CTL_MS];
	assign hb   = ctrl_q[CTL_HB];
	assign ph   = ctrl_q[CTL_PH];
	assign po   = ctrl_q[CTL_PO];
	assign lb   = ctrl_q[CTL_LB];
	assign aren = ctrl_q[CTL_AREN];
	// width code 0 is reserved; treat it as the smallest legal frame
	assign w_last = (ctrl_q[CTL_BM +: 3] == 3'h0) ? 3'h1 : ctrl_q[CTL_BM +: 3];

	// bus slave: one wait state, ack for one cycle, write lands on the ack edge
	assign bus_req = cyc & stb;
	assign wr_go   = bus_req & ack_q & we;
	assign rd_go   = bus_req & ack_q & ~we;
	assign txb_wr  = wr_go & (adr == OFF_TXB) & sel[0];
	assign rxb_rd  = rd_go & (adr == OFF_RXB);
	assign lane16  = {{8{sel[1]}}, {8{sel[0]}}};
	assign ctrl_m  = (en ? CTRL_WMASK_EN : CTRL_WMASK) & lane16;
	assign err_clr = (wr_go && adr == OFF_STAT && sel[0]) ? dat_w[3:0] : 4'h0;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req & ~ack_q;
	end

	always_comb
	begin
		rd_d = '0;
		case (adr)
			OFF_CTRL: rd_d[15:0] = ctrl_q;
			OFF_STAT:
			begin
				rd_d[3:0]         = err_q;
				rd_d[ST_BSY]      = (st_q != ST_IDLE);
				rd_d[ST_TXREQ]    = ~tx_full_q;
				rd_d[ST_RXFULL]   = rx_full_q;
				rd_d[ST_BC +: 3]  = cnt_q;
			end
			OFF_RXB:   rd_d[FRAME_MAX-1:0] = rx_buf_q;
			OFF_BAUD:  rd_d[15:0] = en ? baud_cnt : baud_q;
			OFF_INSEL: rd_d[7:0] = insel_q & INSEL_WMASK;
			default:   rd_d = '0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			dat_r_q <= '0;
		else if (bus_req && !ack_q && !we)
			dat_r_q <= rd_d;
	end

	assign dat_r = dat_r_q;
	assign ack   = ack_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= CTRL_RST;
		else if (wr_go && adr == OFF_CTRL)
			ctrl_q <= (ctrl_q & ~ctrl_m) | (dat_w[15:0] & ctrl_m);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			insel_q <= INSEL_RST;
		else if (wr_go && adr == OFF_INSEL && sel[0])
			insel_q <= dat_w[7:0] & INSEL_WMASK;
	end

	// a write while enabled would corrupt the running count, so it is dropped
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			baud_q <= BAUD_RST;
		else if (wr_go && adr == OFF_BAUD && !en)
			baud_q <= (baud_q & ~lane16) | (dat_w[15:0] & lane16);
	end

	baud_timer #(.WIDTH(BAUD_W)) u_baud (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (en),
		.reload  (baud_q),
		.tick    (tick),
		.count   (baud_cnt)
	);

	input_select3 u_mrx (.pins(master_rx_in), .sel(insel_q[SEL_MIS +: 2]), .y(mrx));
	input_select3 u_srx (.pins(slave_rx_in), .sel(insel_q[SEL_SIS +: 2]), .y(srx));
	input_select3 u_sck (.pins(slave_clock_in), .sel(insel_q[SEL_CIS +: 2]), .y(sck));

	// the receive pin is sampled even while we drive the shared line ourselves
	assign rx_pin = ms ? mrx : srx;
	assign rx_bit = lb ? out_q : rx_pin;

	// edge events: master from its own toggling clock, slave from the picked clock line
	assign m_edge   = ms & en & tick & (st_q != ST_IDLE);
	assign s_edge   = ~ms & en & (sck != sck_prev_q);
	assign edge_go  = m_edge | s_edge;
	assign new_lvl  = ms ? ~sclk_q : sck;
	assign act      = edge_go & ((st_q == ST_SHIFT) | (~ms & st_q == ST_IDLE));
	assign latch_go = act & ((new_lvl != po) == ph);
	assign shift_go = act & ~latch_go;
	assign slv_start = act & ~ms & (st_q == ST_IDLE);
	assign fresh_eff = slv_start ? ~ph : fresh_q;
	assign sh_go    = shift_go & ~fresh_eff;
	assign fin      = latch_go & (cnt_q == w_last);
	assign mst_start = ms & en & tick & (st_q == ST_IDLE) & tx_full_q;
	assign slv_load = ~ms & en & (st_q == ST_IDLE) & tx_full_q & ~edge_go;
	assign end_load = fin & tx_full_q;
	assign load     = mst_start | slv_load | end_load;

	assign rx_new = hb ? {rx_sr_q[FRAME_MAX-2:0], rx_bit}
		: ({rx_bit, rx_sr_q[FRAME_MAX-1:1]} >> (3'h7 - w_last));

	always_comb
	begin
		tx_sr_d = tx_sr_q;
		if (load)
			tx_sr_d = tx_buf_q;
		else if (fin)
			tx_sr_d = rx_new;
		else if (sh_go)
			tx_sr_d = hb ? {tx_sr_q[FRAME_MAX-2:0], 1'b0} : {1'b0, tx_sr_q[FRAME_MAX-1:1]};
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= ST_IDLE;
		else if (!en || arst)
			st_q <= ST_IDLE;
		else
			case (st_q)
				ST_IDLE:
					if (mst_start || slv_start)
						st_q <= ST_SHIFT;
				ST_SHIFT:
					if (fin)
						st_q <= (ms && tx_full_q) ? ST_SHIFT
							: ((new_lvl == po) ? ST_IDLE : ST_TAIL);
				ST_TAIL:
					if (edge_go)
						st_q <= ST_IDLE;
				default:
					st_q <= ST_IDLE;
			endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 3'h0;
		else if (!en || arst || fin)
			cnt_q <= 3'h0;
		else if (latch_go)
			cnt_q <= cnt_q + 3'h1;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sr_q <= '0;
			out_q   <= 1'b0;
			fresh_q <= 1'b0;
		end
		else
		begin
			tx_sr_q <= tx_sr_d;
			// the line keeps the last bit after a frame
			if (load || sh_go || te_hit)
				out_q <= hb ? tx_sr_d[w_last] : tx_sr_d[0];
			if (load)
				fresh_q <= end_load | ~ph;
			else if (shift_go)
				fresh_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			sclk_q <= 1'b0;
		else if (!ms || !en || (st_q == ST_IDLE && !m_edge))
			sclk_q <= po;
		else if (m_edge)
			sclk_q <= ~sclk_q;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_buf_q  <= '0;
			tx_full_q <= 1'b0;
		end
		else if (txb_wr)
		begin
			tx_buf_q  <= dat_w[FRAME_MAX-1:0];
			tx_full_q <= 1'b1;
		end
		else if (load)
			tx_full_q <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_loaded_q <= 1'b0;
		else if (!en)
			tx_loaded_q <= 1'b0;
		else if (load)
			tx_loaded_q <= 1'b1;
		else if (slv_start)
			tx_loaded_q <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_sr_q   <= '0;
			rx_buf_q  <= '0;
			rx_full_q <= 1'b0;
		end
		else
		begin
			if (latch_go)
				rx_sr_q <= hb ? {rx_sr_q[FRAME_MAX-2:0], rx_bit} : {rx_bit, rx_sr_q[FRAME_MAX-1:1]};
			if (fin)
				rx_buf_q <= rx_new;
			// a frame finishing in the read cycle keeps the buffer marked full
			if (fin)
				rx_full_q <= 1'b1;
			else if (rxb_rd)
				rx_full_q <= 1'b0;
		end
	end

	// data history at clock rate for the phase window around each latch edge
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxs1_q     <= 1'b0;
			sck_prev_q <= 1'b0;
			win_q      <= 2'h0;
		end
		else
		begin
			rxs1_q     <= rx_bit;
			sck_prev_q <= sck;
			if (latch_go)
				win_q <= PH_WIN_AFTER;
			else if (win_q != 2'h0)
				win_q <= win_q - 2'h1;
		end
	end

	// slave rate check: half periods are compared with reload+1 clocks
	assign exp_half = {1'b0, baud_q} + 17'h00001;
	assign gap_x2   = {gap_q, 1'b0} + 19'h00002;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			armed_q <= 1'b0;
			gap_q   <= '0;
		end
		else
		begin
			// stays armed after a frame, so a halted master shows up as a baud error
			if (!en || ms || be_hit)
				armed_q <= 1'b0;
			else if (s_edge)
				armed_q <= 1'b1;
			if (!armed_q || s_edge)
				gap_q <= '0;
			else if (gap_q != '1)
				gap_q <= gap_q + 18'h00001;
		end
	end

	assign te_hit = slv_start & ~tx_loaded_q;
	assign re_hit = fin & rx_full_q;
	// window opens one sample before the latch edge, so quarter-rate own data stays clean
	assign pe_hit = en & (latch_go | (win_q != 2'h0)) & (rx_bit != rxs1_q);
	assign be_hit = ~ms & en & armed_q & ((s_edge & (gap_x2 < {2'h0, exp_half}))
		| (gap_q >= {exp_half, 1'b0}));
	assign arst   = be_hit & aren;

	always_comb
	begin
		err_hit         = 4'h0;
		err_hit[ERR_TE] = te_hit;
		err_hit[ERR_RE] = re_hit;
		err_hit[ERR_PE] = pe_hit;
		err_hit[ERR_BE] = be_hit;
	end

	// a hit in the clearing cycle wins over the clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			err_q <= 4'h0;
		else
			err_q <= (err_q & ~err_clr) | err_hit;
	end

	assign error_irq_line = |(err_q & ctrl_q[CTL_ERR_EN +: 4]);
	assign tx_req = ~tx_full_q;

	assign generated_shift_clock      = sclk_q;
	assign generated_shift_clock_oe   = en & ms;
	assign master_out_slave_in_pin    = out_q;
	assign master_out_slave_in_pin_oe = en & ms;
	assign slave_out_master_in_pin    = out_q;
	assign slave_out_master_in_pin_oe = en & ~ms;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	txreq_after_load_a: assert property (load && !txb_wr |=> tx_req)
		else $error("transmit request not raised after buffer move");
	b2b_frame_a: assert property (fin && ms && tx_full_q && !arst
		|=> st_q == ST_SHIFT && cnt_q == 0)
		else $error("master left a gap between back-to-back frames");
	role_lines_a: assert property (en |-> generated_shift_clock_oe == ms
		&& slave_out_master_in_pin_oe == !ms)
		else $error("drivers do not follow the role");
	insel_zero_a: assert property (bus_req && !ack_q && !we && adr == OFF_INSEL
		|=> dat_r[31:6] == 0)
		else $error("reserved input select bits read nonzero");
	baud_live_a: assert property (bus_req && !ack_q && !we && adr == OFF_BAUD && en
		|=> dat_r[15:0] == $past(baud_cnt))
		else $error("baud read did not return the live count");
	flag_sticky_a: assert property (err_q[ERR_PE] && !err_clr[ERR_PE] |=> err_q[ERR_PE])
		else $error("phase error flag dropped without a clear");
	irq_follows_a: assert property (re_hit && ctrl_q[CTL_ERR_EN + ERR_RE]
		##1 ctrl_q[CTL_ERR_EN + ERR_RE] |-> error_irq_line)
		else $error("enabled receive error did not raise the interrupt");
	overrun_a: assert property (fin && rx_full_q |=> err_q[ERR_RE] && rx_full_q
		&& rx_buf_q == $past(rx_new))
		else $error("overrun not flagged or buffer not overwritten");
	slave_only_a: assert property (ms |-> !te_hit && !be_hit)
		else $error("slave-only error raised in master role");
	underrun_a: assert property (slv_start && !tx_loaded_q |=> err_q[ERR_TE])
		else $error("stale slave frame not flagged");
	auto_reset_a: assert property (be_hit && aren |=> st_q == ST_IDLE && cnt_q == 0 && !armed_q)
		else $error("baud error did not reset the channel");

	frame_done_c: cover property (fin ##1 rx_full_q);
	b2b_c: cover property (end_load && ms);
	baud_err_c: cover property (be_hit);
	phase_err_c: cover property (pe_hit && ms);
endmodule

/* sim/ext_master_model.sv */
// external master model driving shift clock and data into the channel in slave role
// assumes an idle-low clock, lsb first and eight-bit frames
module ext_master_model (
	input  wire logic ref_clk,
	output logic      sclk,
	output logic      sdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		sclk = 1'b0;
		sdata = 1'b0;
	end

	// data moves halfway between edges, so either latching edge sees a settled bit
	task automatic send(input logic [7:0] d, input int half);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			sdata <= d[i];
			repeat (half / 2) @(posedge ref_clk);
			sclk <= 1'b1;
			repeat (half) @(posedge ref_clk);
			sclk <= 1'b0;
			repeat (half - half / 2 - 1) @(posedge ref_clk);
		end
		// clock stands still after the frame; released data shows the inverse of its last bit
		sdata <= ~d[7];
	endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the synchronous serial channel
// assumes the external master model is compiled before this file
module tb_top
	import sync_serial_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             ref_clk, rst_n, cyc, stb, we, ack, gsc, gsc_oe, mosi, mosi_oe;
	logic             miso, miso_oe, tx_req, irq, pclk, pdat, prev_clk;
	logic [ADR_W-1:0] adr;
	logic [3:0]       sel;
	logic [DAT_W-1:0] dat_w, dat_r, rd;
	int               errors, num_checks, per, rises, since, gaps;

	sync_serial_channel dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack),
		.generated_shift_clock(gsc), .generated_shift_clock_oe(gsc_oe),
		.slave_clock_in({pclk, ~pclk, 1'b0}), .master_out_slave_in_pin(mosi),
		.master_out_slave_in_pin_oe(mosi_oe), .slave_rx_in({pdat, ~pdat, mosi}),
		.slave_out_master_in_pin(miso), .slave_out_master_in_pin_oe(miso_oe),
		.master_rx_in({pdat, mosi, ~mosi}), .tx_req(tx_req), .error_irq_line(irq)
	);

	ext_master_model ext_u (
		.ref_clk(ref_clk),
		.sclk(pclk),
		.sdata(pdat)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// long idle spans between frames are not gaps; anything short and uneven is
	always @(posedge ref_clk)
	begin
		prev_clk <= gsc;
		since <= since + 1;
		if (gsc === 1'b1 && prev_clk === 1'b0)
		begin
			rises <= rises + 1;
			since <= 1;
			if (since != per && since < 3 * per)
				gaps <= gaps + 1;
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic timeout();
		$display("BAD wait limit expected done seen hang");
		errors++;
		summarize();
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		for (n = 0; n < 50 && ack !== 1'b1; n++)
			@(posedge ref_clk);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
			timeout();
	endtask

	// frame start waits for a baud tick, so the busy poll begins one period later
	task automatic wait_done();
		int n;
		repeat (per) @(posedge ref_clk);
		rd = 32'h10;
		for (n = 0; n < 200 && rd[ST_BSY] !== 1'b0; n++)
			wb(0, OFF_STAT, 0);
		if (n >= 200)
			timeout();
	endtask

	task automatic setup(input logic [15:0] b, input logic [7:0] s, input logic [15:0] c);
		wb(0, OFF_CTRL, 0);
		wb(1, OFF_CTRL, 0);
		wb(1, OFF_BAUD, {16'h0, b});
		per = 2 * (int'(b) + 1);
		wb(1, OFF_INSEL, {24'h0, s});
		wb(1, OFF_CTRL, {16'h0, c});
		// the control write lands on the ack edge; let it settle before pins are looked at
		@(posedge ref_clk);
	endtask

	task automatic t_reset();
		logic [31:0] a;
		chk("tx_req reset", 1, tx_req);
		chk("irq reset", 0, irq);
		wb(0, OFF_STAT, 0);
		chk("status reset", 32'h20, rd);
		wb(0, OFF_CTRL, 0);
		chk("ctrl reset", {16'h0, CTRL_RST}, rd);
		wb(0, OFF_INSEL, 0);
		chk("insel reset", {24'h0, INSEL_RST}, rd);
		wb(1, OFF_INSEL, 32'hFF);
		wb(0, OFF_INSEL, 0);
		chk("insel zero bits", 32'h3F, rd);
		wb(1, 8'h18, 32'hFF);
		wb(0, 8'h18, 0);
		chk("unmapped", 0, rd);
		setup(16'h0100, 8'h00, 16'hC007);
		wb(0, OFF_BAUD, 0);
		a = rd;
		wb(0, OFF_BAUD, 0);
		chk("live count", 1, a != rd && a <= 32'h100);
		wb(1, OFF_BAUD, 32'h55);
		wb(1, OFF_CTRL, 0);
		wb(0, OFF_BAUD, 0);
		chk("reload kept", 32'h100, rd);
		$display("register test done");
	endtask

	task automatic t_phase();
		setup(16'h0000, 8'h01, 16'hC407);
		wb(1, OFF_TXB, 32'h96);
		wait_done();
		wb(0, OFF_STAT, 0);
		chk("phase flag", 1, rd[ERR_PE]);
		chk("no slave errors", 0, rd[ERR_TE] | rd[ERR_BE]);
		chk("phase irq", 1, irq);
		wb(1, OFF_STAT, 32'h4);
		wb(0, OFF_STAT, 0);
		chk("phase cleared", 0, rd[ERR_PE]);
		chk("irq cleared", 0, irq);
		$display("phase test done");
	endtask

	task automatic t_select();
		logic [7:0] d, e;
		int r0;
		setup(16'h0001, 8'h00, 16'hC007);
		chk("master pin oe", 3'b011, {miso_oe, mosi_oe, gsc_oe});
		for (int c = 0; c < 4; c++)
		begin
			d = 8'h3A + 8'(c);
			wb(1, OFF_INSEL, 32'(c));
			r0 = rises;
			wb(1, OFF_TXB, {24'h0, d});
			wait_done();
			e = (c == 0) ? ~d : (c == 1) ? d : (c == 2) ? {8{pdat}} : 8'h00;
			wb(0, OFF_RXB, 0);
			chk("rx select", {24'h0, e}, rd);
			chk("shift rises", 8, rises - r0);
		end
		wb(0, OFF_STAT, 0);
		chk("no phase at quarter rate", 0, rd[ERR_PE]);
		$display("select test done");
	endtask

	task automatic t_b2b();
		int r0, g0;
		setup(16'h0001, 8'h01, 16'hC207);
		// flags left by earlier tests would hide a missing overrun
		wb(1, OFF_STAT, 32'hF);
		wb(0, OFF_STAT, 0);
		chk("flags clear", 0, rd[3:0]);
		r0 = rises;
		g0 = gaps;
		wb(1, OFF_TXB, 32'h11);
		@(posedge ref_clk);
		chk("tx_req full", 0, tx_req);
		repeat (per) @(posedge ref_clk);
		chk("tx_req empty", 1, tx_req);
		wb(1, OFF_TXB, 32'h22);
		wait_done();
		chk("chained rises", 16, rises - r0);
		chk("chain gaps", 0, gaps - g0);
		wb(0, OFF_RXB, 0);
		chk("overwrite", 32'h22, rd);
		wb(0, OFF_STAT, 0);
		chk("overrun flag", 1, rd[ERR_RE]);
		chk("overrun irq", 1, irq);
		wb(1, OFF_STAT, 32'h2);
		@(posedge ref_clk);
		chk("irq clear", 0, irq);
		$display("chained test done");
	endtask

	task automatic t_slave();
		setup(16'h0007, 8'h28, 16'h9907);
		chk("slave pin oe", 3'b100, {miso_oe, mosi_oe, gsc_oe});
		wb(1, OFF_TXB, 32'hFF);
		repeat (2) @(posedge ref_clk);
		chk("slave first bit", 1, miso);
		ext_u.send(8'hC3, 8);
		wb(0, OFF_RXB, 0);
		chk("slave rx", 32'hC3, rd);
		ext_u.send(8'h81, 8);
		wb(0, OFF_STAT, 0);
		chk("stale flag", 1, rd[ERR_TE]);
		repeat (40) @(posedge ref_clk);
		wb(0, OFF_STAT, 0);
		chk("baud flag", 1, rd[ERR_BE]);
		chk("slave irq", 1, irq);
		$display("slave test done");
	endtask

	initial
	begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = '0;
		sel = 4'hF;
		dat_w = '0;
		errors = 0;
		num_checks = 0;
		per = 4;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_phase();
		t_select();
		t_b2b();
		t_slave();
		summarize();
	end
endmodule
